// ==== hw/ecppc_pkg.sv ====
// package: register map, field positions, reset values and types of the port core
package ecppc_pkg;
	// ************************************************************
	// register word indices (byte address is index times 4, decoded from address bits 13:2)
	// ************************************************************
	localparam logic [11:0] ECPPC_IDX_DATA = 12'h000;
	localparam logic [11:0] ECPPC_IDX_STATUS = 12'h001;
	localparam logic [11:0] ECPPC_IDX_CONTROL = 12'h002;
	localparam logic [11:0] ECPPC_IDX_FIFO = 12'h400;
	localparam logic [11:0] ECPPC_IDX_CAPB = 12'h401;
	localparam logic [11:0] ECPPC_IDX_EXTCTL = 12'h402;
	localparam logic [11:0] ECPPC_IDX_IRQSTAT = 12'h403;
	localparam int ECPPC_AW = 14;
	// ************************************************************
	// constants and reset values
	// ************************************************************
	localparam logic [7:0] ECPPC_CAPA_VAL = 8'h10;
	localparam logic [2:0] ECPPC_CAPB_LOW_RST = 3'h7;
	localparam logic [7:0] ECPPC_EXTCTL_RST = 8'h15;
	localparam logic [7:0] ECPPC_CONTROL_RST = 8'hc0;
	localparam int ECPPC_DEPTH = 16;
	localparam logic [4:0] ECPPC_TX_SPACE_THR = 5'h08;
	localparam logic [4:0] ECPPC_RX_FILL_THR = 5'h08;
	localparam logic [1:0] ECPPC_RESP_OKAY = 2'h0;
	localparam logic [1:0] ECPPC_RESP_SLVERR = 2'h2;
	// field positions
	localparam int ECPPC_EC_MODE_LSB = 5;
	localparam int ECPPC_EC_FAULT_DIS = 4;
	localparam int ECPPC_EC_DMA = 3;
	localparam int ECPPC_EC_SVC = 2;
	localparam int ECPPC_CT_DIR = 5;
	localparam int ECPPC_CT_ACKIE = 4;
	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {
		ECPPC_M_COMPAT, ECPPC_M_BIDIR, ECPPC_M_COMPAT_FIFO_WINDOW, ECPPC_M_ECP,
		ECPPC_M_EPP, ECPPC_M_RSVD, ECPPC_M_TEST, ECPPC_M_CONFIG
	} ecppc_mode_e;
	typedef struct packed {
		logic busy;
		logic ack_n;
		logic paper_error;
		logic select;
		logic fault_n;
	} ecppc_lines_s;
	typedef struct packed {
		logic strobe_n;
		logic linefeed_n;
		logic init_n;
		logic select_in_n;
	} ecppc_ctl_s;
endpackage : ecppc_pkg

// ==== hw/ecppc_core.sv ====
// module: parallel port core with AXI4-Lite registers, shared FIFO, handshakes
`timescale 1ns/1ps
`default_nettype none
module ecppc_core
	import ecppc_pkg::*;
#(
	parameter logic [2:0] IRQ_ASSIGN = 3'h0
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// axi4-lite write
	input wire logic [ECPPC_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ECPPC_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// peripheral lines
	input wire ecppc_lines_s lines_in,
	input wire logic [7:0] port_data_lines_i,
	output logic [7:0] port_data_lines_o,
	output logic port_data_lines_oe,
	output ecppc_ctl_s ctl_out,
	// dma and interrupt
	input wire logic dma_tc,
	output logic dma_req,
	output logic irq_line_level
);
	// ************************************************************
	// registers
	// ************************************************************
	logic [7:0] data_q;
	logic [5:0] control_q;
	logic [2:0] mode_q;
	logic fault_irq_disable_q, dma_allow_q, service_irq_mask_q;
	logic [2:0] capb_low_q;
	logic [8:0] mem [ECPPC_DEPTH];
	logic [3:0] wp_q, rp_q;
	logic [4:0] cnt_q;
	logic ack_q, fault_q;
	logic ack_ev_q, fault_ev_q;
	logic [1:0] hs_q;
	logic [7:0] rx_q;
	logic aw_q, w_q;
	logic [ECPPC_AW-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic dir_eff, full, empty, fwd;
	logic wr_go, rd_go;
	logic push, pop, hw_push, hw_pop, host_push, host_pop;
	logic [8:0] push_val;
	logic [7:0] rd_byte;
	logic rd_err, wr_err;
	logic [7:0] status_b, control_b, capb_b, extctl_b;
	logic [11:0] rd_idx, wr_idx;
	logic [2:0] new_mode;
	logic svc_set, svc_ev_q;

	// ************************************************************
	// decode
	// ************************************************************
	assign full = (cnt_q == 5'(ECPPC_DEPTH));
	assign empty = (cnt_q == 5'h00);
	assign dir_eff = (mode_q == ECPPC_M_COMPAT || mode_q == ECPPC_M_COMPAT_FIFO_WINDOW)
		? 1'b0 : control_q[ECPPC_CT_DIR];
	assign fwd = !dir_eff;
	assign rd_idx = s_axi_araddr[13:2];
	assign wr_idx = awaddr_q[13:2];
	assign wr_go = aw_q && w_q && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign status_b = {!lines_in.busy, lines_in.ack_n, lines_in.paper_error,
		lines_in.select, lines_in.fault_n, 3'h7};
	assign control_b = {2'h3, control_q};
	assign capb_b = {1'b0, irq_line_level, IRQ_ASSIGN, 3'h7};
	assign extctl_b = {mode_q, fault_irq_disable_q, dma_allow_q,
		service_irq_mask_q, full, empty};
	assign new_mode = wdata_q[7:5];
	// service condition: terminal count with dma, else fifo threshold
	assign svc_set = !service_irq_mask_q && (dma_allow_q ? dma_tc
		: (fwd ? (5'(ECPPC_DEPTH) - cnt_q) >= ECPPC_TX_SPACE_THR
		: cnt_q >= ECPPC_RX_FILL_THR));

	// host fifo access at 0x400 per mode; config mode maps capability words
	assign host_push = wr_go && wstrb_q[0] && !full && (
		(wr_idx == ECPPC_IDX_FIFO && (mode_q == ECPPC_M_COMPAT_FIFO_WINDOW
		|| (mode_q == ECPPC_M_ECP && fwd) || mode_q == ECPPC_M_TEST))
		|| (wr_idx == ECPPC_IDX_DATA && mode_q == ECPPC_M_ECP && fwd));
	assign host_pop = rd_go && rd_idx == ECPPC_IDX_FIFO && !empty
		&& ((mode_q == ECPPC_M_ECP && dir_eff) || mode_q == ECPPC_M_TEST);
	// reverse ECP capture on ack falling edge
	assign hw_push = mode_q == ECPPC_M_ECP && dir_eff && ack_q
		&& !lines_in.ack_n && !full && !host_push;
	assign hw_pop = hs_q == 2'h2 && !host_pop;
	assign push = host_push || hw_push;
	assign pop = host_pop || hw_pop;
	assign push_val = host_push ? {wr_idx == ECPPC_IDX_DATA, wdata_q[7:0]}
		: {1'b0, port_data_lines_i};

	always_comb begin
		rd_byte = 8'h00;
		rd_err = 1'b0;
		case (rd_idx)
			ECPPC_IDX_DATA: rd_byte = (mode_q == ECPPC_M_BIDIR)
				? port_data_lines_i : data_q;
			ECPPC_IDX_STATUS: rd_byte = status_b;
			ECPPC_IDX_CONTROL: rd_byte = control_b;
			ECPPC_IDX_FIFO: rd_byte = (mode_q == ECPPC_M_CONFIG)
				? ECPPC_CAPA_VAL : mem[rp_q][7:0];
			ECPPC_IDX_CAPB: rd_byte = (mode_q == ECPPC_M_CONFIG) ? capb_b : 8'h00;
			ECPPC_IDX_EXTCTL: rd_byte = extctl_b;
			ECPPC_IDX_IRQSTAT: rd_byte = {6'h00, fault_ev_q, ack_ev_q};
			default: rd_err = 1'b1;
		endcase
	end
	always_comb begin
		case (wr_idx)
			ECPPC_IDX_DATA, ECPPC_IDX_CONTROL, ECPPC_IDX_FIFO, ECPPC_IDX_CAPB,
			ECPPC_IDX_EXTCTL, ECPPC_IDX_IRQSTAT, ECPPC_IDX_STATUS: wr_err = 1'b0;
			default: wr_err = 1'b1;
		endcase
	end

	// ************************************************************
	// axi4-lite slave
	// ************************************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ECPPC_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_err ? ECPPC_RESP_SLVERR : ECPPC_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_q <= 1'b0;
				w_q <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= ECPPC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h0, rd_byte};
				s_axi_rresp <= rd_err ? ECPPC_RESP_SLVERR : ECPPC_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ************************************************************
	// control registers
	// ************************************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			data_q <= 8'h00;
			control_q <= ECPPC_CONTROL_RST[5:0];
			capb_low_q <= ECPPC_CAPB_LOW_RST;
		end else if (wr_go && wstrb_q[0]) begin
			if (wr_idx == ECPPC_IDX_DATA && mode_q <= ECPPC_M_BIDIR)
				data_q <= wdata_q[7:0];
			if (wr_idx == ECPPC_IDX_CONTROL) begin
				control_q[4:0] <= wdata_q[4:0];
				if (mode_q == ECPPC_M_BIDIR)
					control_q[ECPPC_CT_DIR] <= wdata_q[ECPPC_CT_DIR];
			end
			if (wr_idx == ECPPC_IDX_CAPB && mode_q == ECPPC_M_CONFIG)
				capb_low_q <= wdata_q[2:0];
		end
	end
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mode_q <= ECPPC_EXTCTL_RST[7:5];
			fault_irq_disable_q <= ECPPC_EXTCTL_RST[ECPPC_EC_FAULT_DIS];
			dma_allow_q <= ECPPC_EXTCTL_RST[ECPPC_EC_DMA];
			service_irq_mask_q <= ECPPC_EXTCTL_RST[ECPPC_EC_SVC];
		end else begin
			if (wr_go && wstrb_q[0] && wr_idx == ECPPC_IDX_EXTCTL) begin
				if (mode_q <= ECPPC_M_BIDIR || new_mode <= ECPPC_M_BIDIR)
					mode_q <= new_mode;
				fault_irq_disable_q <= wdata_q[ECPPC_EC_FAULT_DIS];
				dma_allow_q <= wdata_q[ECPPC_EC_DMA];
				service_irq_mask_q <= wdata_q[ECPPC_EC_SVC];
			end
			// hardware set wins over a clearing write
			if (svc_set)
				service_irq_mask_q <= 1'b1;
		end
	end

	// ************************************************************
	// shared fifo
	// ************************************************************
	always_ff @(posedge clk_sys) begin
		if (push)
			mem[wp_q] <= push_val;
	end
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wp_q <= 4'h0;
			rp_q <= 4'h0;
			cnt_q <= 5'h00;
		end else if (mode_q == ECPPC_M_COMPAT) begin
			wp_q <= 4'h0;
			rp_q <= 4'h0;
			cnt_q <= 5'h00;
		end else begin
			if (push)
				wp_q <= wp_q + 4'h1;
			if (pop)
				rp_q <= rp_q + 4'h1;
			cnt_q <= cnt_q + 5'(push) - 5'(pop);
		end
	end

	// ************************************************************
	// forward handshake: data and strobe together until busy high, then wait busy low
	// ************************************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			hs_q <= 2'h0;
			rx_q <= 8'h00;
		end else begin
			case (hs_q)
				2'h0: if (!empty && fwd && !lines_in.busy
					&& (mode_q == ECPPC_M_COMPAT_FIFO_WINDOW || mode_q == ECPPC_M_ECP))
					hs_q <= 2'h1;
				2'h1: if (lines_in.busy)
					hs_q <= 2'h2;
				2'h2: hs_q <= 2'h3;
				2'h3: if (!lines_in.busy)
					hs_q <= 2'h0;
				default: hs_q <= 2'h0;
			endcase
			if (mode_q == ECPPC_M_COMPAT)
				hs_q <= 2'h0;
			if (hw_push)
				rx_q <= port_data_lines_i;
		end
	end

	// ************************************************************
	// pins and interrupt
	// ************************************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			port_data_lines_o <= 8'h00;
			port_data_lines_oe <= 1'b0;
			ctl_out <= '1;
		end else begin
			port_data_lines_oe <= !dir_eff;
			port_data_lines_o <= (hs_q != 2'h0 || mode_q == ECPPC_M_TEST)
				? mem[rp_q][7:0] : data_q;
			ctl_out.select_in_n <= !control_q[3];
			ctl_out.init_n <= control_q[2];
			ctl_out.linefeed_n <= (mode_q == ECPPC_M_ECP && hs_q != 2'h0)
				? !mem[rp_q][8] : !control_q[1];
			ctl_out.strobe_n <= (hs_q == 2'h1) ? 1'b0 : !control_q[0];
		end
	end
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ack_q <= 1'b1;
			fault_q <= 1'b1;
			ack_ev_q <= 1'b0;
			fault_ev_q <= 1'b0;
			irq_line_level <= 1'b0;
			dma_req <= 1'b0;
			svc_ev_q <= 1'b0;
		end else begin
			ack_q <= lines_in.ack_n;
			fault_q <= lines_in.fault_n;
			if (wr_go && wstrb_q[0] && wr_idx == ECPPC_IDX_IRQSTAT) begin
				ack_ev_q <= ack_ev_q & ~wdata_q[0];
				fault_ev_q <= fault_ev_q & ~wdata_q[1];
			end
			if (control_q[ECPPC_CT_ACKIE] && !ack_q && lines_in.ack_n)
				ack_ev_q <= 1'b1;
			if (mode_q == ECPPC_M_ECP && !fault_irq_disable_q && fault_q
				&& !lines_in.fault_n)
				fault_ev_q <= 1'b1;
			// only a hardware set raises the service event, not a written 1
			if (wr_go && wstrb_q[0] && wr_idx == ECPPC_IDX_EXTCTL
				&& !wdata_q[ECPPC_EC_SVC])
				svc_ev_q <= 1'b0;
			if (svc_set && mode_q >= ECPPC_M_COMPAT_FIFO_WINDOW)
				svc_ev_q <= 1'b1;
			irq_line_level <= ack_ev_q || fault_ev_q || svc_ev_q;
			dma_req <= dma_allow_q && !service_irq_mask_q
				&& (fwd ? !full : !empty);
		end
	end
endmodule : ecppc_core
`default_nettype wire

// ==== sim/ecppc_core_props.sv ====
// checker: register bus timing and status view of the port core
`timescale 1ns/1ps
`default_nettype none
module ecppc_core_props
	import ecppc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// register bus
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ECPPC_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	// peripheral lines
	input wire ecppc_lines_s lines_in,
	input wire ecppc_ctl_s ctl_out,
	input wire logic port_data_lines_oe
);
	logic st_q;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	// marks a pending read of the status byte
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			st_q <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
			st_q <= s_axi_araddr == {ECPPC_IDX_STATUS, 2'b00};
	end
	sequence s_taken;
		s_axi_awready && s_axi_wready;
	endsequence
	sequence s_answer;
		##2 s_axi_bvalid;
	endsequence
	property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
	a_aw_pulse: assert property (p_aw_pulse) else $error("awready held");
	property p_b_answer; s_taken |-> s_answer; endproperty
	a_b_answer: assert property (p_b_answer) else $error("bvalid late");
	property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_b_once: assert property (p_b_once) else $error("bvalid repeated");
	property p_ar_take; $rose(s_axi_arvalid) |=> s_axi_arready; endproperty
	a_ar_take: assert property (p_ar_take) else $error("arready late");
	property p_r_answer; s_axi_arready |=> s_axi_rvalid; endproperty
	a_r_answer: assert property (p_r_answer) else $error("rvalid late");
	property p_r_byte;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 &&
			(s_axi_rresp == ECPPC_RESP_OKAY || s_axi_rresp == ECPPC_RESP_SLVERR);
	endproperty
	a_r_byte: assert property (p_r_byte) else $error("bad read word");
	property p_status;
		$rose(s_axi_rvalid) && st_q |->
			s_axi_rdata[7:0] == {$past(lines_in) ^ 5'h10, 3'h7};
	endproperty
	a_status: assert property (p_status) else $error("status wrong");
	property p_rst_pins;
		$fell(reset) |-> ctl_out == 4'hf && !port_data_lines_oe;
	endproperty
	a_rst_pins: assert property (p_rst_pins) else $error("pins after reset");
endmodule : ecppc_core_props
bind ecppc_core ecppc_core_props u_ecppc_core_props (.*);
`default_nettype wire

// ==== sim/ecppc_periph_model.sv ====
// partner: peripheral answering the strobe/busy handshake
`timescale 1ns/1ps
`default_nettype none
module ecppc_periph_model
	import ecppc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// port lines
	input wire ecppc_ctl_s ctl_out,
	input wire logic [7:0] port_data_lines_o,
	input wire logic port_data_lines_oe,
	output ecppc_lines_s lines_in,
	output logic [7:0] port_data_lines_i
);
	logic [1:0] st_q;
	logic [8:0] cap_q [0:15];
	int cnt_q;
	// host drive wins, else the peripheral drives 3c
	assign port_data_lines_i = port_data_lines_oe ? port_data_lines_o : 8'h3c;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_q <= 2'h0;
			cnt_q <= 0;
			lines_in <= 5'b01011;
		end else begin
			case (st_q)
				2'h0: if (!ctl_out.strobe_n) begin
					lines_in.busy <= 1'b1;
					cap_q[cnt_q[3:0]] <= {ctl_out.linefeed_n, port_data_lines_o};
					cnt_q <= cnt_q + 1;
					st_q <= 2'h1;
				end
				2'h1: if (ctl_out.strobe_n) begin
					lines_in.ack_n <= 1'b0;
					st_q <= 2'h2;
				end
				default: begin
					lines_in.ack_n <= 1'b1;
					lines_in.busy <= 1'b0;
					st_q <= 2'h0;
				end
			endcase
		end
	end
endmodule : ecppc_periph_model
`default_nettype wire

// ==== sim/test_ecp_parallel_port_core.sv ====
// testbench: register-level sequences against the parallel port core
`timescale 1ns/1ps
`default_nettype none
module test_ecp_parallel_port_core
	import ecppc_pkg::*;
;
	logic clk_sys, reset, dma_tc, dma_req, irq_line_level;
	logic [ECPPC_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, port_data_lines_oe;
	logic [7:0] port_data_lines_i, port_data_lines_o, d;
	logic [8:0] xp [2:5] = '{9'h111, 9'h122, 9'h081, 9'h142};
	ecppc_lines_s lines_in;
	ecppc_ctl_s ctl_out;
	int err_total, samples_checked, cyc;
	ecppc_core u_ecppc_core (.*);
	ecppc_periph_model u_ecppc_periph_model (.*);
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(logic [11:0] ix, logic [7:0] v);
		@(posedge clk_sys);
		s_axi_awaddr <= {ix, 2'b00};
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid || s_axi_wvalid);
		while (!s_axi_bvalid) @(posedge clk_sys);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(logic [11:0] ix, output logic [7:0] v);
		@(posedge clk_sys);
		s_axi_araddr <= {ix, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk_sys); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge clk_sys);
		v = s_axi_rdata[7:0];
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic rdc(logic [11:0] ix, logic [7:0] exp);
		logic [7:0] v;
		rd(ix, v);
		chk("reg", v, exp);
	endtask : rdc
	task automatic md(logic [2:0] m);
		wr(ECPPC_IDX_EXTCTL, {m, 5'h14});
	endtask : md
	task automatic sent(int n);
		while (u_ecppc_periph_model.cnt_q < n) @(posedge clk_sys);
	endtask : sent
	initial begin
		reset = 1'b1;
		dma_tc = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_wdata} = '0;
		{s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hf;
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		rdc(ECPPC_IDX_CONTROL, 8'hc0);
		rdc(ECPPC_IDX_EXTCTL, 8'h15);
		rdc(ECPPC_IDX_STATUS, 8'hdf);
		rd(12'h010, d);
		chk("resp", {6'h0, rsp}, {6'h0, ECPPC_RESP_SLVERR});
		wr(12'h010, 8'h00);
		chk("bresp", {6'h0, rsp}, {6'h0, ECPPC_RESP_SLVERR});
		$display("test registers done");
		wr(ECPPC_IDX_CONTROL, 8'h0b);
		rdc(ECPPC_IDX_CONTROL, 8'hcb);
		chk("pins", {4'h0, ctl_out}, 8'h00);
		wr(ECPPC_IDX_CONTROL, 8'h14);
		repeat (8) @(posedge clk_sys);
		chk("pins", {4'h0, ctl_out}, 8'h0f);
		chk("irq", {7'h0, irq_line_level}, 8'h01);
		wr(ECPPC_IDX_IRQSTAT, 8'h03);
		repeat (2) @(posedge clk_sys);
		chk("irq", {7'h0, irq_line_level}, 8'h00);
		wr(ECPPC_IDX_CONTROL, 8'h05);
		wr(ECPPC_IDX_CONTROL, 8'h04);
		repeat (8) @(posedge clk_sys);
		chk("irq", {7'h0, irq_line_level}, 8'h00);
		$display("test control done");
		wr(ECPPC_IDX_DATA, 8'ha5);
		wr(ECPPC_IDX_CONTROL, 8'h24);
		repeat (2) @(posedge clk_sys);
		chk("pd", port_data_lines_o, 8'ha5);
		chk("oe", {7'h0, port_data_lines_oe}, 8'h01);
		md(3'h1);
		wr(ECPPC_IDX_CONTROL, 8'h24);
		rdc(ECPPC_IDX_DATA, 8'h3c);
		chk("oe", {7'h0, port_data_lines_oe}, 8'h00);
		wr(ECPPC_IDX_CONTROL, 8'h04);
		$display("test data done");
		md(3'h6);
		for (int i = 0; i < 17; i++)
			wr(ECPPC_IDX_FIFO, 8'h60 + 8'(i));
		rdc(ECPPC_IDX_EXTCTL, 8'hd6);
		md(3'h3);
		rdc(ECPPC_IDX_EXTCTL, 8'hd6);
		for (int i = 0; i < 16; i++)
			rdc(ECPPC_IDX_FIFO, 8'h60 + 8'(i));
		rdc(ECPPC_IDX_EXTCTL, 8'hd5);
		wr(ECPPC_IDX_FIFO, 8'h01);
		md(3'h0);
		rdc(ECPPC_IDX_EXTCTL, 8'h15);
		chk("sent", 8'(u_ecppc_periph_model.cnt_q), 8'h02);
		$display("test fifo done");
		md(3'h2);
		wr(ECPPC_IDX_FIFO, 8'h11);
		wr(ECPPC_IDX_FIFO, 8'h22);
		sent(4);
		md(3'h0);
		md(3'h3);
		wr(ECPPC_IDX_DATA, 8'h81);
		wr(ECPPC_IDX_FIFO, 8'h42);
		sent(6);
		for (int i = 2; i < 6; i++) begin
			chk("cap", u_ecppc_periph_model.cap_q[i][7:0], xp[i][7:0]);
			chk("lf", 8'(u_ecppc_periph_model.cap_q[i][8]), 8'(xp[i][8]));
		end
		$display("test link done");
		md(3'h0);
		md(3'h7);
		rdc(ECPPC_IDX_FIFO, 8'h10);
		wr(ECPPC_IDX_CAPB, 8'h00);
		rdc(ECPPC_IDX_CAPB, 8'h07);
		$display("test config done");
		md(3'h0);
		md(3'h1);
		wr(ECPPC_IDX_CONTROL, 8'h24);
		md(3'h3);
		wr(ECPPC_IDX_CONTROL, 8'h25);
		wr(ECPPC_IDX_CONTROL, 8'h24);
		repeat (4) @(posedge clk_sys);
		rdc(ECPPC_IDX_EXTCTL, 8'h74);
		rdc(ECPPC_IDX_FIFO, 8'h3c);
		$display("test reverse done");
		md(3'h0);
		wr(ECPPC_IDX_EXTCTL, 8'h58);
		repeat (2) @(posedge clk_sys);
		chk("dreq", {7'h0, dma_req}, 8'h01);
		chk("irq", {7'h0, irq_line_level}, 8'h00);
		dma_tc <= 1'b1;
		@(posedge clk_sys);
		dma_tc <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rdc(ECPPC_IDX_EXTCTL, 8'h5d);
		chk("dreq", {7'h0, dma_req}, 8'h00);
		chk("irq", {7'h0, irq_line_level}, 8'h01);
		wr(ECPPC_IDX_EXTCTL, 8'h50);
		rdc(ECPPC_IDX_EXTCTL, 8'h55);
		$display("test dma done");
		stop_test();
	end
endmodule : test_ecp_parallel_port_core
`default_nettype wire
